// ### rtl/mdp_top.sv
// Decode, paging, general logic array, port muxing and power control of the companion core.
// How it works
// - The main flash is split into 16 equal sectors, each with its own select.
// - The secondary flash has 4 sectors, each with its own select.
// - The address decode array turns addresses into selects with no storage.
// - The logic array has sixteen registered output cells and eight combinational outputs.
// - Twenty-four input cells can each be enabled to feed pin values to the array.
// - With the fast bit clear the array holds its outputs until an input changes.
// - Bits of the second power register block signals from entering the array.
// - An 8-bit page register forms the upper decode bits for up to 256 pages.
// - A remap control moves the flash blocks between pages for reprogramming.
// - The MCU chip select drives the decode; it and the read, write and ALE strobes are also array inputs.
// - Port E can carry mode select, test clock, data in, data out, status and error.
// - The MCU programs one flash while running from the other flash or SRAM.
// - Array and configuration are loaded only over the serial port, never by MCU writes.
// - In non-multiplexed mode port F carries data bits 0 to 7.
// - In non-multiplexed 16-bit mode port G carries data bits 8 to 15.
// - The power-down unit switches functions off while the MCU is idle.
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "mdp_map.svh"
module mdp_top #(
  parameter int unsigned APD_CYCLES = `MDP_APD_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic [15:0] mcu_addr_i,
  input  wire logic        mcu_rd_n_i,
  input  wire logic        mcu_wr_n_i,
  input  wire logic        mcu_ale_i,
  input  wire logic        mcu_csi_n_i,
  input  wire logic [15:0] mem_rdata_i,
  output logic      [15:0] mem_wdata_o,
  output logic      [15:0] main_sel_o,
  output logic      [3:0]  sec_sel_o,
  output logic             sram_sel_o,
  output logic             reg_sel_o,
  output logic             power_down_o,
  output logic      [15:0] cell_out_o,
  output logic      [7:0]  comb_out_o,
  input  wire logic [7:0]  pe_i,
  output logic      [7:0]  pe_o,
  output logic      [7:0]  pe_oe_o,
  input  wire logic [7:0]  port_f_pins_i,
  output logic      [7:0]  port_f_pins_o,
  output logic      [7:0]  port_f_pins_oe_o,
  input  wire logic [7:0]  port_g_pins_i,
  output logic      [7:0]  port_g_pins_o,
  output logic      [7:0]  port_g_pins_oe_o
);
  mdp_pkg::mdp_byte_t page_r, vm_r, pwr0_r, pwr2_r, jtag_en_r;
  mdp_pkg::mdp_byte_t pe_out_r, pe_dir_r, pf_out_r, pf_dir_r, pg_out_r, pg_dir_r;
  logic [7:0]               rdata_r;
  logic [`MDP_CFG_W-1:0]    cfg_r;
  logic [`MDP_CFG_W-1:0]    chain_r;
  logic [7:0]               shift_cnt_r;
  logic                     busy_r;
  logic                     err_r;
  logic                     tck_q_r;
  logic                     tms_q_r;
  logic [31:0]              in_bus;
  logic [31:0]              in_q_r;
  logic                     chg;
  logic                     fast;
  logic [15:0]              omc_r;
  logic [15:0]              omc_nxt;
  logic [7:0]               comb_now;
  logic [7:0]               comb_hold_r;
  logic [3:0]               stb_q_r;
  logic                     activity;
  mdp_pkg::mdp_apd_t        apd_r;
  logic [23:0]              apd_cnt_r;
  logic                     mem_hit;
  logic [15:0]              wdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.

  mdp_dec_if dif ();
  assign dif.addr  = mcu_addr_i;
  assign dif.page  = page_r;
  assign dif.remap = vm_r[`MDP_VM_REMAP_BIT];
  assign dif.csi_n = mcu_csi_n_i;
  assign dif.pd    = (apd_r == mdp_pkg::MDP_APD_DOWN);

  mdp_decode u_decode (
    .d (dif.dec)
  );

  // While one flash is selected for execution, the other can be selected for
  // programming in another page; the decoder never selects both in the same access.
  assign main_sel_o   = dif.main_sel;
  assign sec_sel_o    = dif.sec_sel;
  assign sram_sel_o   = dif.sram_sel;
  assign reg_sel_o    = dif.reg_sel;
  assign power_down_o = dif.pd;
  assign mem_hit      = |{dif.main_sel, dif.sec_sel, dif.sram_sel};

  ////////////////////////////////////////////////////////////////////////////////
  // Register port.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_r    <= `MDP_ZERO_RST;
      vm_r      <= `MDP_ZERO_RST;
      pwr0_r    <= `MDP_PWR0_RST;
      pwr2_r    <= `MDP_ZERO_RST;
      jtag_en_r <= `MDP_ZERO_RST;
      pe_out_r  <= `MDP_ZERO_RST;
      pe_dir_r  <= `MDP_ZERO_RST;
      pf_out_r  <= `MDP_ZERO_RST;
      pf_dir_r  <= `MDP_ZERO_RST;
      pg_out_r  <= `MDP_ZERO_RST;
      pg_dir_r  <= `MDP_ZERO_RST;
    end else if (ce_i && reg_wr_i) begin
      // The configuration chain has no write path from this port.
      if (reg_addr_i == `MDP_REG_PAGE) begin
        page_r <= reg_wdata_i;
      end else if (reg_addr_i == `MDP_REG_VM) begin
        vm_r <= reg_wdata_i;
      end else if (reg_addr_i == `MDP_REG_PWR0) begin
        pwr0_r <= reg_wdata_i;
      end else if (reg_addr_i == `MDP_REG_PWR2) begin
        pwr2_r <= reg_wdata_i;
      end else if (reg_addr_i == `MDP_REG_JTAG_EN) begin
        jtag_en_r <= reg_wdata_i;
      end else if (reg_addr_i == `MDP_REG_PE_OUT) begin
        pe_out_r <= reg_wdata_i;
      end else if (reg_addr_i == `MDP_REG_PE_DIR) begin
        pe_dir_r <= reg_wdata_i;
      end else if (reg_addr_i == `MDP_REG_PF_OUT) begin
        pf_out_r <= reg_wdata_i;
      end else if (reg_addr_i == `MDP_REG_PF_DIR) begin
        pf_dir_r <= reg_wdata_i;
      end else if (reg_addr_i == `MDP_REG_PG_OUT) begin
        pg_out_r <= reg_wdata_i;
      end else if (reg_addr_i == `MDP_REG_PG_DIR) begin
        pg_dir_r <= reg_wdata_i;
      end
    end
  end

  // Read data stand for the one cycle after the strobe and return to zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
    end else if (ce_i) begin
      rdata_r <= 8'h00;
      if (reg_rd_i) begin
        if (reg_addr_i == `MDP_REG_PAGE) begin
          rdata_r <= page_r;
        end else if (reg_addr_i == `MDP_REG_VM) begin
          rdata_r <= vm_r;
        end else if (reg_addr_i == `MDP_REG_PWR0) begin
          rdata_r <= pwr0_r;
        end else if (reg_addr_i == `MDP_REG_PWR2) begin
          rdata_r <= pwr2_r;
        end else if (reg_addr_i == `MDP_REG_JTAG_EN) begin
          rdata_r <= jtag_en_r;
        end else if (reg_addr_i == `MDP_REG_PE_IN) begin
          rdata_r <= pe_i;
        end else if (reg_addr_i == `MDP_REG_PE_OUT) begin
          rdata_r <= pe_out_r;
        end else if (reg_addr_i == `MDP_REG_PE_DIR) begin
          rdata_r <= pe_dir_r;
        end else if (reg_addr_i == `MDP_REG_PF_IN) begin
          rdata_r <= port_f_pins_i;
        end else if (reg_addr_i == `MDP_REG_PG_IN) begin
          rdata_r <= port_g_pins_i;
        end else if (reg_addr_i == `MDP_REG_PF_OUT) begin
          rdata_r <= pf_out_r;
        end else if (reg_addr_i == `MDP_REG_PG_OUT) begin
          rdata_r <= pg_out_r;
        end else if (reg_addr_i == `MDP_REG_PF_DIR) begin
          rdata_r <= pf_dir_r;
        end else if (reg_addr_i == `MDP_REG_PG_DIR) begin
          rdata_r <= pg_dir_r;
        end else if (reg_addr_i == `MDP_REG_OMC_A) begin
          rdata_r <= omc_r[7:0];
        end else if (reg_addr_i == `MDP_REG_OMC_B) begin
          rdata_r <= omc_r[15:8];
        end else if (reg_addr_i == `MDP_REG_STATUS) begin
          rdata_r <= {4'h0, err_r, busy_r, ~fast & ~chg, dif.pd};
        end
      end
    end
  end
  assign reg_rdata_o = rdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial configuration port on port E.

  // Pins 0..2 are inputs; a falling mode select ends the load, and a shift whose
  // 8-bit count is not 202 is rejected so a half-loaded chain never reaches the array.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tck_q_r     <= 1'b0;
      tms_q_r     <= 1'b0;
      chain_r     <= '0;
      cfg_r       <= '0;
      shift_cnt_r <= 8'h00;
      busy_r      <= 1'b0;
      err_r       <= 1'b0;
    end else if (ce_i) begin
      tck_q_r <= pe_i[1];
      tms_q_r <= pe_i[0];
      if (jtag_en_r[0] && pe_i[0] && pe_i[1] && !tck_q_r) begin
        chain_r     <= {pe_i[2], chain_r[`MDP_CFG_W-1:1]};
        shift_cnt_r <= shift_cnt_r + 8'h01;
        busy_r      <= 1'b1;
        err_r       <= 1'b0;
      end else if (jtag_en_r[0] && tms_q_r && !pe_i[0]) begin
        busy_r      <= 1'b0;
        shift_cnt_r <= 8'h00;
        if (shift_cnt_r == `MDP_CFG_LEN) begin
          cfg_r <= chain_r;
        end else begin
          err_r <= 1'b1;
        end
      end
    end
  end

  always_comb begin
    pe_o    = pe_out_r;
    pe_oe_o = pe_dir_r;
    if (jtag_en_r[0]) begin
      pe_o[3]      = chain_r[0];
      pe_o[4]      = busy_r;
      pe_o[5]      = ~err_r;
      pe_oe_o[5:0] = 6'h38;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // General logic array.

  assign fast = pwr0_r[`MDP_PWR0_FAST_BIT];

  // Blocked inputs sit at zero so they stop toggling the array.
  always_comb begin
    in_bus        = 32'h0000_0000;
    in_bus[23:0]  = {pe_i, port_g_pins_i, port_f_pins_i} & cfg_r[23:0];
    if (pwr2_r[`MDP_PWR2_CELL_BIT]) begin
      in_bus[23:0] = 24'h00_0000;
    end
    in_bus[24] = mcu_rd_n_i & ~pwr2_r[`MDP_PWR2_STB_BIT];
    in_bus[25] = mcu_wr_n_i & ~pwr2_r[`MDP_PWR2_STB_BIT];
    in_bus[26] = mcu_csi_n_i & ~pwr2_r[`MDP_PWR2_CSI_BIT];
    in_bus[27] = mcu_ale_i & ~pwr2_r[`MDP_PWR2_ALE_BIT];
  end

  assign chg = (in_bus != in_q_r);

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      omc_nxt[i] = in_bus[cfg_r[`MDP_CFG_ROC_BASE + 6*i +: 5]]
                   ^ cfg_r[`MDP_CFG_ROC_BASE + 6*i + 5];
    end
    for (int j = 0; j < 8; j++) begin
      comb_now[j] = in_bus[cfg_r[`MDP_CFG_CMB_BASE + 10*j +: 5]]
                    & in_bus[cfg_r[`MDP_CFG_CMB_BASE + 10*j + 5 +: 5]];
    end
  end

  // Out of fast mode the array only evaluates on an input change, which
  // saves power at the cost of one cycle of extra latency on the combinational outputs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_q_r      <= 32'h0000_0000;
      omc_r       <= 16'h0000;
      comb_hold_r <= 8'h00;
    end else if (ce_i) begin
      in_q_r <= in_bus;
      if (fast || chg) begin
        omc_r       <= omc_nxt;
        comb_hold_r <= comb_now;
      end
    end
  end
  assign cell_out_o = omc_r;
  assign comb_out_o = fast ? comb_now : comb_hold_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Automatic power-down unit.

  assign activity = ({mcu_ale_i, mcu_csi_n_i, mcu_wr_n_i, mcu_rd_n_i} != stb_q_r);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stb_q_r   <= 4'hf;
      apd_r     <= mdp_pkg::MDP_APD_ACTIVE;
      apd_cnt_r <= 24'h00_0000;
    end else if (ce_i) begin
      stb_q_r <= {mcu_ale_i, mcu_csi_n_i, mcu_wr_n_i, mcu_rd_n_i};
      case (apd_r)
        mdp_pkg::MDP_APD_ACTIVE: begin
          apd_cnt_r <= 24'h00_0000;
          if (pwr0_r[`MDP_PWR0_APD_BIT] && !activity) begin
            apd_r <= mdp_pkg::MDP_APD_COUNT;
          end
        end
        mdp_pkg::MDP_APD_COUNT: begin
          if (activity || !pwr0_r[`MDP_PWR0_APD_BIT]) begin
            apd_r <= mdp_pkg::MDP_APD_ACTIVE;
          end else if (apd_cnt_r == 24'(APD_CYCLES - 1)) begin
            apd_r <= mdp_pkg::MDP_APD_DOWN;
          end else begin
            apd_cnt_r <= apd_cnt_r + 24'h00_0001;
          end
        end
        mdp_pkg::MDP_APD_DOWN: begin
          if (activity || !pwr0_r[`MDP_PWR0_APD_BIT]) begin
            apd_r <= mdp_pkg::MDP_APD_ACTIVE;
          end
        end
        default: begin
          apd_r <= mdp_pkg::MDP_APD_ACTIVE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Ports F and G as MCU I/O or non-multiplexed data bus.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdata_r <= 16'h0000;
    end else if (ce_i && cfg_r[`MDP_CFG_NONMUX] && !mcu_wr_n_i && mem_hit) begin
      wdata_r <= {port_g_pins_i, port_f_pins_i};
    end
  end
  assign mem_wdata_o = wdata_r;

  always_comb begin
    port_f_pins_o    = pf_out_r;
    port_f_pins_oe_o = pf_dir_r;
    port_g_pins_o    = pg_out_r;
    port_g_pins_oe_o = pg_dir_r;
    if (cfg_r[`MDP_CFG_NONMUX]) begin
      port_f_pins_o    = mem_rdata_i[7:0];
      port_f_pins_oe_o = {8{!mcu_rd_n_i && mem_hit}};
      if (cfg_r[`MDP_CFG_BUS16]) begin
        port_g_pins_o    = mem_rdata_i[15:8];
        port_g_pins_oe_o = {8{!mcu_rd_n_i && mem_hit}};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  main_sector_map_a: assert property (
    (!mcu_csi_n_i && !dif.pd && !vm_r[0] && page_r[7:4] == 4'h0 && !dif.reg_sel)
    |-> main_sel_o == (16'h0001 << page_r[3:0]))
    else $error("main sector select does not follow the page");
  sec_sector_map_a: assert property (
    (!mcu_csi_n_i && !dif.pd && !vm_r[0] && page_r == 8'h10 && !dif.reg_sel)
    |-> sec_sel_o == (4'h1 << mcu_addr_i[15:14]))
    else $error("secondary sector select wrong");
  remap_swap_a: assert property (
    (!mcu_csi_n_i && !dif.pd && vm_r[0] && page_r == 8'h00 && !dif.reg_sel)
    |-> main_sel_o == 16'h0000 && sec_sel_o != 4'h0)
    else $error("remap did not move the secondary flash");
  standby_hold_a: assert property (
    (ce_i && !fast && !chg) |=> omc_r == $past(omc_r))
    else $error("array outputs moved in standby");
  block_inputs_a: assert property (
    pwr2_r[0] |-> in_bus[25:24] == 2'b00)
    else $error("blocked strobes reached the array");
  power_down_off_a: assert property (
    dif.pd |-> !mem_hit && !reg_sel_o)
    else $error("select active during power-down");
  jtag_pins_a: assert property (
    jtag_en_r[0] |-> pe_oe_o[5:0] == 6'h38 && pe_o[3] == chain_r[0] && pe_o[5] == !err_r)
    else $error("port E serial pins not muxed");
  nonmux_drive_a: assert property (
    (cfg_r[200] && !mcu_rd_n_i && mem_hit)
    |-> port_f_pins_oe_o == 8'hff && port_f_pins_o == mem_rdata_i[7:0])
    else $error("port F not driving read data");
  cfg_locked_a: assert property (
    (reg_wr_i && !jtag_en_r[0]) |=> cfg_r == $past(cfg_r))
    else $error("configuration changed by a register write");
endmodule // mdp_top

// ### rtl/mdp_map.svh
// Register offsets, field positions, reset values and timing counts of the decode core.
`ifndef MDP_MAP_SVH
`define MDP_MAP_SVH

`define MDP_REG_OMC_A     8'h20
`define MDP_REG_OMC_B     8'h21
`define MDP_REG_PE_IN     8'h30
`define MDP_REG_PE_OUT    8'h34
`define MDP_REG_PE_DIR    8'h36
`define MDP_REG_PF_IN     8'h40
`define MDP_REG_PG_IN     8'h41
`define MDP_REG_PF_OUT    8'h44
`define MDP_REG_PG_OUT    8'h45
`define MDP_REG_PF_DIR    8'h46
`define MDP_REG_PG_DIR    8'h47
`define MDP_REG_PWR0      8'hb0
`define MDP_REG_PWR2      8'hb4
`define MDP_REG_JTAG_EN   8'hc7
`define MDP_REG_PAGE      8'he0
`define MDP_REG_VM        8'he2
`define MDP_REG_STATUS    8'he4

`define MDP_PWR0_APD_BIT  1
`define MDP_PWR0_FAST_BIT 3
`define MDP_PWR2_STB_BIT  0
`define MDP_PWR2_CSI_BIT  1
`define MDP_PWR2_ALE_BIT  2
`define MDP_PWR2_CELL_BIT 3
`define MDP_VM_REMAP_BIT  0

`define MDP_PWR0_RST      8'h08
`define MDP_ZERO_RST      8'h00

`define MDP_CSIOP_HI      8'h7f
`define MDP_MAIN_PAGE_HI  4'h0
`define MDP_SEC_PAGE      8'h10
`define MDP_SRAM_PAGE     8'h20

`define MDP_CFG_LEN       8'hca
`define MDP_CFG_W         202
`define MDP_CFG_ROC_BASE  24
`define MDP_CFG_CMB_BASE  120
`define MDP_CFG_NONMUX    200
`define MDP_CFG_BUS16     201

`define MDP_CLK_MHZ       10
`define MDP_APD_TIME_US   1000
`define MDP_APD_CYCLES    (`MDP_APD_TIME_US * `MDP_CLK_MHZ)

`endif

// ### rtl/mdp_pkg.sv
// Types shared by the decode core modules.
package mdp_pkg;
  typedef logic [7:0] mdp_byte_t;
  typedef enum logic [1:0] {
    MDP_APD_ACTIVE = 2'b00,
    MDP_APD_COUNT  = 2'b01,
    MDP_APD_DOWN   = 2'b11
  } mdp_apd_t;
endpackage

// ### rtl/mdp_dec_if.sv
// Address and select signals between the core and its address decode array.
`timescale 1ns/10ps
interface mdp_dec_if;
  logic [15:0] addr;
  logic [7:0]  page;
  logic        remap;
  logic        csi_n;
  logic        pd;
  logic [15:0] main_sel;
  logic [3:0]  sec_sel;
  logic        sram_sel;
  logic        reg_sel;
  modport dec  (input addr, page, remap, csi_n, pd,
                output main_sel, sec_sel, sram_sel, reg_sel);
  modport core (output addr, page, remap, csi_n, pd,
                input main_sel, sec_sel, sram_sel, reg_sel);
endinterface

// ### rtl/mdp_decode.sv
// Combinational address decode array producing memory and register selects.
`timescale 1ns/10ps
`include "mdp_map.svh"
module mdp_decode (
  mdp_dec_if.dec d
);
  logic [7:0] pg;
  logic       ok;

  // No storage here: selects follow address and page in the same cycle.
  always_comb begin
    pg         = d.remap ? (d.page ^ `MDP_SEC_PAGE) : d.page;
    ok         = !d.csi_n && !d.pd;
    d.main_sel = 16'h0000;
    d.sec_sel  = 4'h0;
    d.sram_sel = 1'b0;
    d.reg_sel  = 1'b0;
    if (ok && d.addr[15:8] == `MDP_CSIOP_HI) begin
      d.reg_sel = 1'b1;
    end else if (ok && pg[7:4] == `MDP_MAIN_PAGE_HI) begin
      d.main_sel = 16'h0001 << pg[3:0];
    end else if (ok && pg == `MDP_SEC_PAGE) begin
      d.sec_sel = 4'h1 << d.addr[15:14];
    end else if (ok && pg == `MDP_SRAM_PAGE && !d.addr[15]) begin
      d.sram_sel = 1'b1;
    end
  end
endmodule // mdp_decode

// ### verif/mdp_mcu_model.sv
// Behavioural model of the microcontroller bus facing the core.
`timescale 1ns/10ps
module mdp_mcu_model (
  input  wire logic        clk_i,
  output logic      [15:0] addr_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic             ale_o,
  output logic             csi_n_o
);
  initial begin
    addr_o  = 16'h0000;
    rd_n_o  = 1'b1;
    wr_n_o  = 1'b1;
    ale_o   = 1'b0;
    csi_n_o = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic place(input logic [15:0] a);
    @(posedge clk_i);
    addr_o  <= a;
    csi_n_o <= 1'b0;
  endtask
  // The strobe stays low until the bench closes the access, so slow cycles come for free.
  task automatic open_access(input logic [15:0] a, input logic wr);
    @(posedge clk_i);
    addr_o  <= a;
    csi_n_o <= 1'b0;
    ale_o   <= 1'b1;
    @(posedge clk_i);
    ale_o   <= 1'b0;
    rd_n_o  <= wr;
    wr_n_o  <= ~wr;
  endtask
  // A released address shows the inverse of its last value so a stale decode cannot pass.
  task automatic close_access();
    @(posedge clk_i);
    rd_n_o  <= 1'b1;
    wr_n_o  <= 1'b1;
    csi_n_o <= 1'b1;
    addr_o  <= ~addr_o;
  endtask
endmodule // mdp_mcu_model

// ### verif/mdp_top_tb.sv
// Self-checking bench of the decode, paging, port and power core.
`timescale 1ns/10ps
module mdp_top_tb;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         ce_i = 1'b1;
  logic [7:0]   ra = 8'h00;
  logic [7:0]   wd = 8'h00;
  logic         rw = 1'b0;
  logic         rr = 1'b0;
  logic [7:0]   rdo;
  wire  [15:0]  ma;
  wire          mrd;
  wire          mwr;
  wire          male;
  wire          mcs;
  logic [15:0]  mrdata = 16'h0000;
  logic [7:0]   pe = 8'h00;
  logic [7:0]   pf = 8'h3c;
  logic [7:0]   pg = 8'h00;
  logic [15:0]  wdo;
  logic [15:0]  msel;
  logic [3:0]   ssel;
  logic         srs;
  logic         rgs;
  logic         pd;
  logic [15:0]  co;
  logic [7:0]   peo;
  logic [7:0]   peoe;
  logic [7:0]   cmo;
  logic [7:0]   pfo;
  logic [7:0]   pfoe;
  logic [7:0]   pgo;
  logic [7:0]   pgoe;
  logic [201:0] cfg;
  int           mismatches = 0;
  int           checked = 0;

  always #50 clk_i = ~clk_i;

  mdp_mcu_model mcu (.clk_i(clk_i), .addr_o(ma), .rd_n_o(mrd), .wr_n_o(mwr), .ale_o(male),
                     .csi_n_o(mcs));

  mdp_top #(.APD_CYCLES(8)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(ra), .reg_wdata_i(wd),
    .reg_wr_i(rw), .reg_rd_i(rr), .reg_rdata_o(rdo), .mcu_addr_i(ma), .mcu_rd_n_i(mrd),
    .mcu_wr_n_i(mwr), .mcu_ale_i(male), .mcu_csi_n_i(mcs), .mem_rdata_i(mrdata),
    .mem_wdata_o(wdo), .main_sel_o(msel), .sec_sel_o(ssel), .sram_sel_o(srs),
    .reg_sel_o(rgs), .power_down_o(pd), .cell_out_o(co), .comb_out_o(cmo), .pe_i(pe),
    .pe_o(peo), .pe_oe_o(peoe), .port_f_pins_i(pf), .port_f_pins_o(pfo),
    .port_f_pins_oe_o(pfoe), .port_g_pins_i(pg), .port_g_pins_o(pgo),
    .port_g_pins_oe_o(pgoe));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    ra <= a;
    wd <= d;
    rw <= 1'b1;
    @(posedge clk_i);
    rw <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    ra <= a;
    rr <= 1'b1;
    @(posedge clk_i);
    rr <= 1'b0;
    #1 chk(rdo, e);
  endtask
  task automatic sel(input logic [15:0] a, input logic [21:0] e);
    mcu.place(a);
    #1 chk({msel, ssel, srs, rgs}, e);
  endtask
  // The test clock stands low between bits, each bit takes two cycles.
  task automatic shift(input int n);
    @(posedge clk_i);
    pe[0] <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      pe[1] <= 1'b1;
      pe[2] <= cfg[i];
      @(posedge clk_i);
      pe[1] <= 1'b0;
    end
    #1 chk({peoe[5:0], peo[4]}, {6'h38, 1'b1});
    @(posedge clk_i);
    pe[0] <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk(peo[5:4], {n == 202, 1'b0});
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    cfg = '0;
    cfg[0] = 1'b1;
    cfg[28:24] = 5'd24;
    cfg[41] = 1'b1;
    cfg[201:200] = 2'b11;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(8'hb0, 8'h08);
    rdc(8'he0, 8'h00);
    rdc(8'hb4, 8'h00);
    rdc(8'h99, 8'h00);
    wr(8'h20, 8'hff);
    rdc(8'h20, 8'h00);
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(8'he0, 8'h07);
    ce_i <= 1'b1;
    rdc(8'he0, 8'h00);
    for (int p = 0; p < 16; p++) begin
      wr(8'he0, 8'(p));
      sel(16'h1234, {16'h0001 << p, 6'h00});
    end
    wr(8'he0, 8'h10);
    for (int k = 0; k < 4; k++)
      sel({k[1:0], 14'h0123}, {16'h0000, 4'h1 << k, 2'b00});
    wr(8'he0, 8'h20);
    sel(16'h0100, 22'h000002);
    sel(16'h8100, 22'h000000);
    sel(16'h7f10, 22'h000001);
    mcu.close_access();
    #1 chk({msel, ssel, srs, rgs}, 22'h000000);
    wr(8'he0, 8'h00);
    wr(8'he2, 8'h01);
    sel(16'h0000, {16'h0000, 4'h1, 2'b00});
    wr(8'he2, 8'h00);
    sel(16'h0000, {16'h0001, 6'h00});
    wr(8'h46, 8'hff);
    wr(8'h44, 8'ha5);
    #1 chk({pfoe, pfo}, 16'hffa5);
    rdc(8'h40, 8'h3c);
    wr(8'h46, 8'h00);
    wr(8'he0, 8'h03);
    mcu.close_access();
    wr(8'hb0, 8'h0a);
    repeat (5) @(posedge clk_i);
    #1 chk(pd, 1'b0);
    for (int i = 0; i < 20 && pd !== 1'b1; i++)
      @(posedge clk_i);
    #1 chk(pd, 1'b1);
    rdc(8'he4, 8'h01);
    mcu.place(16'h1234);
    #1 chk({msel, pd}, 17'h00001);
    @(posedge clk_i);
    #1 chk({msel, pd}, {16'h0008, 1'b0});
    wr(8'hb0, 8'h08);
    wr(8'hc7, 8'h01);
    shift(3);
    shift(202);
    repeat (2) @(posedge clk_i);
    rdc(8'h20, 8'h05);
    @(posedge clk_i);
    pf <= 8'h01;
    rdc(8'h20, 8'hfb);
    chk(cmo, 8'hff);
    wr(8'hb4, 8'h01);
    rdc(8'h20, 8'hfa);
    wr(8'hb4, 8'h00);
    wr(8'hb0, 8'h00);
    rdc(8'he4, 8'h02);
    wr(8'hb0, 8'h08);
    @(posedge clk_i);
    mrdata <= 16'hbeef;
    mcu.open_access(16'h1234, 1'b0);
    #1 chk({pgoe, pgo, pfoe, pfo}, 32'hffbeffef);
    @(posedge clk_i);
    #1 chk(co[0], 1'b0);
    mcu.close_access();
    @(posedge clk_i);
    pf <= 8'h5a;
    pg <= 8'hc3;
    mcu.open_access(16'h1234, 1'b1);
    @(posedge clk_i);
    #1 chk(wdo, 16'hc35a);
    mcu.close_access();
    conclude();
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    conclude();
  end
endmodule // mdp_top_tb
